// [common/phy_port_pkg.sv]
// Constants and types shared by both ends of the media and symbol-pair port.
// Assumes both ends and the bench run on one 100 MHz clock; link clocks are plain inputs.
// How it works
// - Alternate clock and data pins idle unless enabled
// - Enabled: output clock recovered from media input
// - Enabled: output recovered data aligned to that clock
// - Alternate receive data synchronous to its clock
// - Transmit clock driven only when its enable set
// - Transmit stream leaves as serial media data
// - Serial media input feeds the clock recovery unit
// - Signal detect marks incoming line activity
// - Indicate word carries odd parity over ten bits
// - Indicate control flag high for control symbols
// - First symbol on bits 7:4, second 3:0
// - Request word arrives with odd parity
// - Request control flag high for control symbols
// - Request first symbol on bits 7:4
package phy_port_pkg;
  localparam int SYM_W           = 8;
  localparam int WORD_W          = 9;
  localparam int FRAME_BITS      = 10;
  localparam int BUF_DEPTH       = 2;
  localparam int MEDIA_RATE_MBPS = 125;
  localparam int MEDIA_CLOCK_MHZ = 125;
  localparam int CLK_PERIOD_NS   = 10;
  localparam int LINK_PERIOD_NS  = 80;
  localparam int LINK_HALF_CYC   = LINK_PERIOD_NS / (2 * CLK_PERIOD_NS);

  localparam logic [2:0] DIV_LAST     = 3'(LINK_HALF_CYC - 1);
  localparam logic [3:0] WORD_LAST    = 4'h8;
  localparam logic [3:0] FRAME_LAST   = 4'h9;
  localparam logic       START_BIT    = 1'b1;
  localparam logic       IDLE_LEVEL   = 1'b0;
  localparam logic       ENABLE_RESET = 1'b0;

  typedef logic [SYM_W-1:0]  sym_pair_t;
  typedef logic [WORD_W-1:0] word_t;
  typedef enum logic [1:0] {RX_IDLE = 2'h1, RX_SHIFT = 2'h2} rx_state_t;
  typedef enum logic [1:0] {TX_IDLE = 2'h1, TX_SEND = 2'h2} tx_state_t;
endpackage

// [common/phy_port_if.sv]
// Pins between the physical-layer end and its partner (media side and MAC or peer).
// Assumes both ends sit in one clock domain for the parallel port.
`timescale 1ns/1ps
interface phy_port_if;
  import phy_port_pkg::*;
  logic      media_line_clock;
  logic      media_serial_in;
  logic      signal_detect;
  logic      alt_receive_clock_in;
  logic      alt_receive_data_in;
  logic      recovered_clock_out;
  logic      recovered_data_out;
  logic      media_serial_out;
  logic      transmit_clock_out;
  logic      indicate_valid;
  logic      indicate_ready;
  logic      indicate_parity;
  logic      indicate_control_flag;
  sym_pair_t indicate_symbols;
  logic      request_valid;
  logic      request_ready;
  logic      request_parity;
  logic      request_control_flag;
  sym_pair_t request_symbols;

  modport phy (
    input  media_line_clock, media_serial_in, signal_detect, alt_receive_clock_in, alt_receive_data_in,
    input  indicate_ready, request_valid, request_parity, request_control_flag, request_symbols,
    output recovered_clock_out, recovered_data_out, media_serial_out, transmit_clock_out,
    output indicate_valid, indicate_parity, indicate_control_flag, indicate_symbols, request_ready
  );
  modport partner (
    output media_line_clock, media_serial_in, signal_detect, alt_receive_clock_in, alt_receive_data_in,
    output indicate_ready, request_valid, request_parity, request_control_flag, request_symbols,
    input  recovered_clock_out, recovered_data_out, media_serial_out, transmit_clock_out,
    input  indicate_valid, indicate_parity, indicate_control_flag, indicate_symbols, request_ready
  );
endinterface

// [rtl/pair_buffer.sv]
// Small ring buffer with valid and ready on both sides.
// Assumes one clock; flags are registered so ready and valid come from flops.
`timescale 1ns/1ps
module pair_buffer #(
  parameter int WIDTH = 9,
  parameter int DEPTH = 2
) (
  // System
  input  logic             clk_i,
  input  logic             reset_n_i,
  // Fill side
  input  logic             in_valid_i,
  input  logic [WIDTH-1:0] in_data_i,
  output logic             in_ready_o,
  // Drain side
  output logic             out_valid_o,
  output logic [WIDTH-1:0] out_data_o,
  input  logic             out_ready_i
);
  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam logic [PW-1:0] PTR_LAST = PW'(DEPTH - 1);

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [PW-1:0]    wr_q, wr_d, rd_q, rd_d;
  logic             full_q, full_d, empty_q, empty_d, ready_q, ready_d;
  logic             push, pop;

  // Own flop so the ready pin comes straight from a register
  assign in_ready_o  = ready_q;
  assign out_valid_o = ~empty_q;
  assign out_data_o  = mem_q[rd_q];

  always_comb begin
    push    = in_valid_i & ~full_q;
    pop     = out_ready_i & ~empty_q;
    wr_d    = push ? ((wr_q == PTR_LAST) ? '0 : wr_q + 1'b1) : wr_q;
    rd_d    = pop ? ((rd_q == PTR_LAST) ? '0 : rd_q + 1'b1) : rd_q;
    full_d  = full_q;
    empty_d = empty_q;
    if (push && !pop) begin
      full_d  = (wr_d == rd_q);
      empty_d = 1'b0;
    end else if (pop && !push) begin
      empty_d = (rd_d == wr_q);
      full_d  = 1'b0;
    end
    ready_d = ~full_d;
  end

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      wr_q    <= '0;
      rd_q    <= '0;
      full_q  <= 1'b0;
      ready_q <= 1'b1;
      empty_q <= 1'b1;
    end else begin
      wr_q    <= wr_d;
      rd_q    <= rd_d;
      full_q  <= full_d;
      ready_q <= ready_d;
      empty_q <= empty_d;
    end
  end

  for (genvar i = 0; i < DEPTH; i++) begin : g_entry
    always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
        mem_q[i] <= '0;
      end else if (push && wr_q == PW'(i)) begin
        mem_q[i] <= in_data_i;
      end
    end
  end
endmodule

// [rtl/phy_port_device.sv]
// Physical-layer end: media receive and recovery, alternate receive path,
// indicate word output, request word input with parity check, serial transmit.
// Assumes link clocks are slow against clk_i (at least four cycles per half period).
`timescale 1ns/1ps
module phy_port_device (
  // System
  input  logic clk_i,
  input  logic reset_n_i,
  // Configuration
  input  logic alt_media_enable_i,
  input  logic transmit_clock_enable_i,
  // Management status
  input  logic status_clear_i,
  output logic line_active_o,
  output logic parity_error_o,
  output logic indicate_overrun_o,
  // Link
  phy_port_if.phy link
);
  import phy_port_pkg::*;

  // Pin order: line clock, serial in, signal detect, alt clock, alt data
  logic [4:0] pin_raw, meta_q, sync_q;
  logic       en_q, transmit_clock_enable_q;
  logic       media_clk_s, media_bit_s, sd_s, alt_clk_s, alt_bit_s;
  logic       rx_clk, rx_bit;

  assign pin_raw = {link.media_line_clock, link.media_serial_in, link.signal_detect,
                    link.alt_receive_clock_in, link.alt_receive_data_in};
  assign {media_clk_s, media_bit_s, sd_s, alt_clk_s, alt_bit_s} = sync_q;

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      meta_q <= '0;
      sync_q <= '0;
      en_q   <= ENABLE_RESET;
      transmit_clock_enable_q <= ENABLE_RESET;
    end else begin
      meta_q <= pin_raw;
      sync_q <= meta_q;
      en_q   <= alt_media_enable_i;
      transmit_clock_enable_q <= transmit_clock_enable_i;
    end
  end

  // Enabled: core listens to the alternate pins, otherwise to the media pins
  assign rx_clk = en_q ? alt_clk_s : media_clk_s;
  assign rx_bit = en_q ? alt_bit_s : media_bit_s;

  // Recovered clock and data share one delay, so they stay aligned
  logic rec_clk_q, rec_clk_d, rec_bit_q, rec_bit_d;

  always_comb begin
    rec_clk_d = en_q & media_clk_s;
    rec_bit_d = en_q & media_bit_s;
  end

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      rec_clk_q <= 1'b0;
      rec_bit_q <= 1'b0;
    end else begin
      rec_clk_q <= rec_clk_d;
      rec_bit_q <= rec_bit_d;
    end
  end

  assign link.recovered_clock_out = rec_clk_q;
  assign link.recovered_data_out  = rec_bit_q;

  // Receive deserialiser: start bit, control flag, then first symbol MSB first
  rx_state_t rx_state_q, rx_state_d;
  logic [3:0] rx_cnt_q, rx_cnt_d;
  word_t      rx_sh_q, rx_sh_d, rx_word;
  logic       rx_prev_q, rx_rise, ind_push, ind_space;

  always_comb begin
    rx_rise    = rx_clk & ~rx_prev_q;
    rx_word    = {rx_sh_q[WORD_W-2:0], rx_bit};
    rx_state_d = rx_state_q;
    rx_cnt_d   = rx_cnt_q;
    rx_sh_d    = rx_sh_q;
    ind_push   = 1'b0;
    if (!sd_s) begin
      // Lost signal abandons a partial word
      rx_state_d = RX_IDLE;
    end else if (rx_rise) begin
      unique case (rx_state_q)
        RX_IDLE: begin
          if (rx_bit == START_BIT) begin
            rx_state_d = RX_SHIFT;
            rx_cnt_d   = '0;
          end
        end
        RX_SHIFT: begin
          rx_sh_d  = rx_word;
          rx_cnt_d = rx_cnt_q + 4'h1;
          if (rx_cnt_q == WORD_LAST) begin
            ind_push   = 1'b1;
            rx_state_d = RX_IDLE;
          end
        end
        default: rx_state_d = RX_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      rx_state_q <= RX_IDLE;
      rx_cnt_q   <= '0;
      rx_sh_q    <= '0;
      rx_prev_q  <= 1'b0;
    end else begin
      rx_state_q <= rx_state_d;
      rx_cnt_q   <= rx_cnt_d;
      rx_sh_q    <= rx_sh_d;
      rx_prev_q  <= rx_clk;
    end
  end

  // Indicate path: buffer, then an output stage so the port pins come from flops
  word_t ind_buf_word, ind_word_q, ind_word_d;
  logic  ind_buf_valid, ind_take;
  logic  ind_valid_q, ind_valid_d, ind_par_q, ind_par_d;

  pair_buffer #(
    .WIDTH (WORD_W),
    .DEPTH (BUF_DEPTH)
  ) u_ind_buf (
    .clk_i       (clk_i),
    .reset_n_i   (reset_n_i),
    .in_valid_i  (ind_push),
    .in_data_i   (rx_word),
    .in_ready_o  (ind_space),
    .out_valid_o (ind_buf_valid),
    .out_data_o  (ind_buf_word),
    .out_ready_i (ind_take)
  );

  always_comb begin
    ind_take    = ind_buf_valid & (~ind_valid_q | link.indicate_ready);
    ind_valid_d = ind_valid_q;
    ind_word_d  = ind_word_q;
    ind_par_d   = ind_par_q;
    if (ind_take) begin
      ind_valid_d = 1'b1;
      ind_word_d  = ind_buf_word;
      ind_par_d   = ~(^ind_buf_word);
    end else if (link.indicate_ready) begin
      ind_valid_d = 1'b0;
    end
  end

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      ind_valid_q <= 1'b0;
      ind_word_q  <= '0;
      ind_par_q   <= 1'b1;
    end else begin
      ind_valid_q <= ind_valid_d;
      ind_word_q  <= ind_word_d;
      ind_par_q   <= ind_par_d;
    end
  end

  assign link.indicate_valid        = ind_valid_q;
  assign link.indicate_parity       = ind_par_q;
  assign link.indicate_control_flag = ind_word_q[WORD_W-1];
  assign link.indicate_symbols      = ind_word_q[SYM_W-1:0];

  // Request path: parity checked on acceptance; bad words still pass through
  word_t tx_word;
  logic  tx_avail, tx_pop, req_take, req_bad;
  logic  perr_q, perr_d, ovr_q, ovr_d, line_q;

  pair_buffer #(
    .WIDTH (WORD_W),
    .DEPTH (BUF_DEPTH)
  ) u_req_buf (
    .clk_i       (clk_i),
    .reset_n_i   (reset_n_i),
    .in_valid_i  (link.request_valid),
    .in_data_i   ({link.request_control_flag, link.request_symbols}),
    .in_ready_o  (link.request_ready),
    .out_valid_o (tx_avail),
    .out_data_o  (tx_word),
    .out_ready_i (tx_pop)
  );

  always_comb begin
    req_take = link.request_valid & link.request_ready;
    req_bad  = ~(^{link.request_parity, link.request_control_flag, link.request_symbols});
    perr_d   = status_clear_i ? 1'b0 : perr_q;
    ovr_d    = status_clear_i ? 1'b0 : ovr_q;
    // A set in the clearing cycle wins
    if (req_take && req_bad) begin
      perr_d = 1'b1;
    end
    if (ind_push && !ind_space) begin
      ovr_d = 1'b1;
    end
  end

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      perr_q <= 1'b0;
      ovr_q  <= 1'b0;
      line_q <= 1'b0;
    end else begin
      perr_q <= perr_d;
      ovr_q  <= ovr_d;
      line_q <= sd_s;
    end
  end

  assign parity_error_o     = perr_q;
  assign indicate_overrun_o = ovr_q;
  assign line_active_o      = line_q;

  // Transmit: divider makes the bit clock; data changes on its falling half
  tx_state_t tx_state_q, tx_state_d;
  logic [2:0]            div_q, div_d;
  logic [3:0]            tx_cnt_q, tx_cnt_d;
  logic [FRAME_BITS-1:0] tx_sh_q, tx_sh_d;
  logic                  phase_q, phase_d, half, fall;
  logic                  ser_q, ser_d, txc_q, txc_d;

  always_comb begin
    half       = (div_q == DIV_LAST);
    div_d      = half ? '0 : div_q + 3'h1;
    phase_d    = phase_q ^ half;
    fall       = half & phase_q;
    tx_state_d = tx_state_q;
    tx_cnt_d   = tx_cnt_q;
    tx_sh_d    = tx_sh_q;
    ser_d      = ser_q;
    tx_pop     = 1'b0;
    if (fall) begin
      unique case (tx_state_q)
        TX_IDLE: begin
          ser_d = IDLE_LEVEL;
          if (tx_avail) begin
            tx_pop     = 1'b1;
            ser_d      = START_BIT;
            tx_sh_d    = {tx_word, 1'b0};
            tx_cnt_d   = 4'h1;
            tx_state_d = TX_SEND;
          end
        end
        TX_SEND: begin
          ser_d    = tx_sh_q[FRAME_BITS-1];
          tx_sh_d  = {tx_sh_q[FRAME_BITS-2:0], 1'b0};
          tx_cnt_d = tx_cnt_q + 4'h1;
          if (tx_cnt_q == FRAME_LAST) begin
            tx_state_d = TX_IDLE;
          end
        end
        default: tx_state_d = TX_IDLE;
      endcase
    end
    txc_d = transmit_clock_enable_q & phase_d;
  end

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      tx_state_q <= TX_IDLE;
      div_q      <= '0;
      tx_cnt_q   <= '0;
      tx_sh_q    <= '0;
      phase_q    <= 1'b0;
      ser_q      <= IDLE_LEVEL;
      txc_q      <= 1'b0;
    end else begin
      tx_state_q <= tx_state_d;
      div_q      <= div_d;
      tx_cnt_q   <= tx_cnt_d;
      tx_sh_q    <= tx_sh_d;
      phase_q    <= phase_d;
      ser_q      <= ser_d;
      txc_q      <= txc_d;
    end
  end

  assign link.media_serial_out   = ser_q;
  assign link.transmit_clock_out = txc_q;
endmodule

// [rtl/phy_port_partner.sv]
// Far end: media receiver making the line clock and serial stream, and a MAC
// or peer that sends request words and takes indicate words.
// Assumes the same clock as the physical-layer end for the parallel port.
`timescale 1ns/1ps
module phy_port_partner (
  // System
  input  logic                   clk_i,
  input  logic                   reset_n_i,
  // Media words to send on the line
  input  logic                   line_active_i,
  input  logic                   media_valid_i,
  input  phy_port_pkg::word_t    media_word_i,
  output logic                   media_ready_o,
  // Request words to the device
  input  logic                   req_valid_i,
  input  logic                   req_ctrl_i,
  input  phy_port_pkg::sym_pair_t req_symbols_i,
  output logic                   req_ready_o,
  // Indicate words from the device
  output logic                   ind_valid_o,
  output phy_port_pkg::word_t    ind_word_o,
  output logic                   ind_parity_ok_o,
  input  logic                   ind_ready_i,
  // Link
  phy_port_if.partner link
);
  import phy_port_pkg::*;

  // Request and indicate holding registers
  logic      rq_valid_q, rq_valid_d, rq_par_q, rq_par_d, rq_ctrl_q, rq_ctrl_d;
  sym_pair_t rq_sym_q, rq_sym_d;
  logic      iv_q, iv_d, iok_q, iok_d;
  word_t     iw_q, iw_d;
  logic      sd_q;

  always_comb begin
    rq_valid_d = rq_valid_q & ~link.request_ready;
    rq_par_d   = rq_par_q;
    rq_ctrl_d  = rq_ctrl_q;
    rq_sym_d   = rq_sym_q;
    if (req_valid_i && !rq_valid_q) begin
      rq_valid_d = 1'b1;
      rq_ctrl_d  = req_ctrl_i;
      rq_sym_d   = req_symbols_i;
      rq_par_d   = ~(^{req_ctrl_i, req_symbols_i});
    end
    iv_d  = iv_q & ~ind_ready_i;
    iw_d  = iw_q;
    iok_d = iok_q;
    if (link.indicate_valid && !iv_q) begin
      iv_d  = 1'b1;
      iw_d  = {link.indicate_control_flag, link.indicate_symbols};
      iok_d = ^{link.indicate_parity, link.indicate_control_flag, link.indicate_symbols};
    end
  end

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      rq_valid_q <= 1'b0;
      rq_par_q   <= 1'b1;
      rq_ctrl_q  <= 1'b0;
      rq_sym_q   <= '0;
      iv_q       <= 1'b0;
      iw_q       <= '0;
      iok_q      <= 1'b0;
      sd_q       <= 1'b0;
    end else begin
      rq_valid_q <= rq_valid_d;
      rq_par_q   <= rq_par_d;
      rq_ctrl_q  <= rq_ctrl_d;
      rq_sym_q   <= rq_sym_d;
      iv_q       <= iv_d;
      iw_q       <= iw_d;
      iok_q      <= iok_d;
      sd_q       <= line_active_i;
    end
  end

  assign req_ready_o               = ~rq_valid_q;
  assign link.request_valid        = rq_valid_q;
  assign link.request_parity       = rq_par_q;
  assign link.request_control_flag = rq_ctrl_q;
  assign link.request_symbols      = rq_sym_q;
  assign link.indicate_ready       = ~iv_q;
  assign ind_valid_o               = iv_q;
  assign ind_word_o                = iw_q;
  assign ind_parity_ok_o           = iok_q;
  assign link.signal_detect        = sd_q;

  // Line serialiser, same framing as the device transmitter
  logic [2:0]            div_q, div_d;
  logic [3:0]            cnt_q, cnt_d;
  logic [FRAME_BITS-1:0] sh_q, sh_d;
  logic                  ph_q, ph_d, ser_q, ser_d, busy_q, busy_d, half, fall;

  always_comb begin
    half   = (div_q == DIV_LAST);
    div_d  = half ? '0 : div_q + 3'h1;
    ph_d   = ph_q ^ half;
    fall   = half & ph_q;
    cnt_d  = cnt_q;
    sh_d   = sh_q;
    ser_d  = ser_q;
    busy_d = busy_q;
    if (fall) begin
      if (busy_q) begin
        ser_d = sh_q[FRAME_BITS-1];
        sh_d  = {sh_q[FRAME_BITS-2:0], 1'b0};
        cnt_d = cnt_q + 4'h1;
        busy_d = (cnt_q != FRAME_LAST);
      end else if (media_valid_i) begin
        ser_d  = START_BIT;
        sh_d   = {media_word_i, 1'b0};
        cnt_d  = 4'h1;
        busy_d = 1'b1;
      end else begin
        ser_d = IDLE_LEVEL;
      end
    end
  end

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      div_q  <= '0;
      cnt_q  <= '0;
      sh_q   <= '0;
      ph_q   <= 1'b0;
      ser_q  <= IDLE_LEVEL;
      busy_q <= 1'b0;
    end else begin
      div_q  <= div_d;
      cnt_q  <= cnt_d;
      sh_q   <= sh_d;
      ph_q   <= ph_d;
      ser_q  <= ser_d;
      busy_q <= busy_d;
    end
  end

  // Ready only in the cycle a word can be loaded
  assign media_ready_o = fall & ~busy_q;
  // Alternate pins carry the same stream, data kept in step with its clock
  assign link.media_line_clock     = ph_q;
  assign link.media_serial_in      = ser_q;
  assign link.alt_receive_clock_in = ph_q;
  assign link.alt_receive_data_in  = ser_q;
endmodule

// [dv/phy_port_monitor.sv]
// Assertions on the link between the physical-layer end and its partner.
// Assumes one clk_i domain; the bench instantiates it beside the interface.
`timescale 1ns/1ps
module phy_port_monitor (
  // System
  input logic                    clk_i,
  input logic                    reset_n_i,
  // Media side
  input logic                    media_line_clock,
  input logic                    media_serial_in,
  input logic                    recovered_clock_out,
  input logic                    recovered_data_out,
  input logic                    media_serial_out,
  input logic                    transmit_clock_out,
  // Indicate path
  input logic                    indicate_valid,
  input logic                    indicate_ready,
  input logic                    indicate_parity,
  input logic                    indicate_control_flag,
  input phy_port_pkg::sym_pair_t indicate_symbols,
  // Request path
  input logic                    request_valid,
  input logic                    request_ready,
  input logic                    request_parity,
  input logic                    request_control_flag,
  input phy_port_pkg::sym_pair_t request_symbols
);
  import phy_port_pkg::*;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!reset_n_i);

  sequence s_ind_held;
    indicate_valid && $stable({indicate_parity, indicate_control_flag, indicate_symbols});
  endsequence
  sequence s_txc_low;
    !transmit_clock_out [*4];
  endsequence
  sequence s_req_held;
    request_valid && $stable({request_parity, request_control_flag, request_symbols});
  endsequence

  AST_IND_ODD: assert property (
    indicate_valid |-> ^{indicate_parity, indicate_control_flag, indicate_symbols})
    else $error("indicate word parity is even");
  AST_IND_HOLD: assert property (indicate_valid && !indicate_ready |=> s_ind_held)
    else $error("indicate word changed while stalled");
  AST_REQ_ODD: assert property (
    request_valid |-> ^{request_parity, request_control_flag, request_symbols})
    else $error("request word parity is even");
  AST_REQ_HOLD: assert property (request_valid && !request_ready |=> s_req_held)
    else $error("request word changed before it was taken");
  AST_REQ_FULL: assert property ($fell(request_ready) |-> $past(request_valid))
    else $error("request buffer filled without a take");
  AST_REC_CLK: assert property (recovered_clock_out |-> $past(media_line_clock, 3))
    else $error("recovered clock not from the line clock");
  AST_REC_SRC: assert property (recovered_data_out |-> $past(media_serial_in, 3))
    else $error("recovered data not from the serial input");
  AST_REC_ALIGN: assert property (
    $rose(recovered_clock_out) |-> ##1 $stable(recovered_data_out) [*3])
    else $error("recovered data moved while its clock was high");
  AST_TXC_LOW: assert property ($fell(transmit_clock_out) |-> s_txc_low)
    else $error("transmit clock low half too short");
  AST_SER_EDGE: assert property ($changed(media_serial_out) |-> !transmit_clock_out)
    else $error("serial output moved while transmit clock high");
endmodule

// [dv/phy_port_and_alt_pmd_io_bench.sv]
// Bench joining the physical-layer end and its partner, plus a raw-driven second end.
// Assumes the partner makes the 80 ns line clock and one 100 MHz clock for all.
`timescale 1ns/1ps
module phy_port_and_alt_pmd_io_bench;
  import phy_port_pkg::*;
  logic      clk_i = 1'b0;
  logic      reset_n_i = 1'b0;
  logic      alt_en, tx_en, clr, act, mv, rv, rc, ir, rc_seen, txc_seen;
  logic      la, pe, pe_b, mr, rr, iv, ip, ovr;
  word_t     mw, iw, sw;
  sym_pair_t rs;
  int        bad_count = 0;
  int        checks = 0;
  int        cyc = 0;
  phy_port_if link();
  phy_port_if link_b();

  phy_port_device u_phy_port_device (.clk_i, .reset_n_i, .alt_media_enable_i(alt_en),
    .transmit_clock_enable_i(tx_en), .status_clear_i(clr), .line_active_o(la),
    .parity_error_o(pe), .indicate_overrun_o(ovr), .link(link.phy));
  // Second end takes one word that breaks the parity rule on purpose, then two good ones
  phy_port_device u_phy_port_device_b (.clk_i, .reset_n_i, .alt_media_enable_i(alt_en),
    .transmit_clock_enable_i(tx_en), .status_clear_i(clr), .line_active_o(),
    .parity_error_o(pe_b), .indicate_overrun_o(), .link(link_b.phy));
  phy_port_partner u_phy_port_partner (.clk_i, .reset_n_i, .line_active_i(act), .media_valid_i(mv),
    .media_word_i(mw), .media_ready_o(mr), .req_valid_i(rv), .req_ctrl_i(rc), .req_symbols_i(rs),
    .req_ready_o(rr), .ind_valid_o(iv), .ind_word_o(iw), .ind_parity_ok_o(ip), .ind_ready_i(ir),
    .link(link.partner));
  phy_port_monitor u_phy_port_monitor (.clk_i, .reset_n_i,
    .media_line_clock(link.media_line_clock), .media_serial_in(link.media_serial_in),
    .recovered_clock_out(link.recovered_clock_out), .recovered_data_out(link.recovered_data_out),
    .media_serial_out(link.media_serial_out), .transmit_clock_out(link.transmit_clock_out),
    .indicate_valid(link.indicate_valid), .indicate_ready(link.indicate_ready),
    .indicate_parity(link.indicate_parity), .indicate_control_flag(link.indicate_control_flag),
    .indicate_symbols(link.indicate_symbols), .request_valid(link.request_valid),
    .request_ready(link.request_ready), .request_parity(link.request_parity),
    .request_control_flag(link.request_control_flag), .request_symbols(link.request_symbols));

  always #(CLK_PERIOD_NS / 2) clk_i = ~clk_i;

  always @(negedge clk_i) begin
    rc_seen = rc_seen | link.recovered_clock_out | link.recovered_data_out;
    txc_seen = txc_seen | link.transmit_clock_out;
  end

  always @(posedge clk_i) begin
    cyc++;
    if (cyc == 10000) begin
      bad_count++;
      print_verdict();
    end
  end

  task automatic check(input string name, input logic [8:0] seen, input logic [8:0] exp);
    checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask

  // Ready is looked at on the falling edge, where a comb pulse has settled
  task automatic wait_take(input int k);
    int   n;
    logic got;
    n = 0;
    got = 1'b0;
    while (!got && n < 400) begin
      @(negedge clk_i);
      got = (((k == 0) ? mr : (k == 1) ? rr : link_b.request_ready) === 1'b1);
      @(posedge clk_i);
      n++;
    end
    #1;
  endtask

  task automatic send_media(input word_t w);
    int n;
    mv = 1'b1;
    mw = w;
    wait_take(0);
    mv = 1'b0;
    n = 0;
    while (iv !== 1'b1 && n < 500) begin
      tick(1);
      n++;
    end
    check("ind_word", iw, w);
    check("ind_parity_ok", {8'h00, ip}, 9'h001);
    ir = 1'b1;
    tick(1);
    ir = 1'b0;
  endtask

  // Serial frame: start bit, then control flag and symbols, sampled on transmit clock rise
  task automatic send_req(input logic c, input sym_pair_t s);
    int   n;
    int   k;
    logic p;
    rv = 1'b1;
    rc = c;
    rs = s;
    wait_take(1);
    rv = 1'b0;
    k = -1;
    n = 0;
    p = 1'b1;
    sw = '0;
    while (k < 9 && n < 2000) begin
      @(negedge clk_i);
      n++;
      if (link.transmit_clock_out === 1'b1 && !p) begin
        if (k >= 0) begin
          sw = {sw[7:0], link.media_serial_out};
          k++;
        end else if (link.media_serial_out === 1'b1) begin
          k = 0;
        end
      end
      p = link.transmit_clock_out;
    end
    tick(1);
    check("serial_word", sw, {c, s});
  endtask

  task automatic push_b(input logic p, input logic c, input sym_pair_t s);
    link_b.request_valid = 1'b1;
    link_b.request_parity = p;
    link_b.request_control_flag = c;
    link_b.request_symbols = s;
    wait_take(2);
  endtask

  initial begin
    {alt_en, tx_en, clr, act, mv, rv, rc, ir, rc_seen, txc_seen} = '0;
    {mw, rs} = '0;
    {link_b.media_line_clock, link_b.media_serial_in, link_b.signal_detect, link_b.alt_receive_clock_in,
      link_b.alt_receive_data_in, link_b.request_valid, link_b.request_control_flag} = '0;
    link_b.request_symbols = '0;
    link_b.request_parity = 1'b1;
    link_b.indicate_ready = 1'b1;
    repeat (12) @(posedge clk_i);
    #1 reset_n_i = 1'b1;
    act = 1'b1;
    tick(6);
    check("line_active", {8'h00, la}, 9'h001);
    send_media(9'h1A5);
    send_media(9'h03C);
    check("rec_off", {8'h00, rc_seen}, 9'h000);
    check("txc_off", {8'h00, txc_seen}, 9'h000);
    // Enable just after a line clock rise, so the recovered clock starts with a whole high half
    @(posedge link.media_line_clock) #1;
    alt_en = 1'b1;
    tx_en = 1'b1;
    send_media(9'h0C3);
    send_media(9'h1F0);
    check("rec_on", {8'h00, rc_seen}, 9'h001);
    check("txc_on", {8'h00, txc_seen}, 9'h001);
    send_req(1'b1, 8'h5A);
    send_req(1'b0, 8'hC3);
    // Hold the request up so words queue back to back and the buffer fills
    rv = 1'b1;
    tick(12);
    wait_take(1);
    rv = 1'b0;
    check("parity_ok", {8'h00, pe}, 9'h000);
    check("no_overrun", {8'h00, ovr}, 9'h000);
    push_b(1'b0, 1'b0, 8'h00);
    push_b(1'b1, 1'b0, 8'h00);
    push_b(1'b0, 1'b1, 8'h00);
    check("req_full", {8'h00, link_b.request_ready}, 9'h000);
    link_b.request_valid = 1'b0;
    tick(2);
    check("parity_err", {8'h00, pe_b}, 9'h001);
    tick(400);
    check("req_drained", {8'h00, link_b.request_ready}, 9'h001);
    clr = 1'b1;
    tick(1);
    clr = 1'b0;
    tick(1);
    check("parity_clr", {8'h00, pe_b}, 9'h000);
    act = 1'b0;
    tick(6);
    check("line_quiet", {8'h00, la}, 9'h000);
    print_verdict();
  end
endmodule
